//--- hw/nvsc_host.sv
`timescale 1ns/1ns
`default_nettype none
module nvsc_host #(
  parameter int STORE_WAIT = nvsc_pkg::STORE_CYCLES,
  parameter int POWERUP_WAIT = nvsc_pkg::POWERUP_COPY_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire logic [nvsc_pkg::OP_W-1:0] cmd_op,
  input wire logic [nvsc_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [nvsc_pkg::DATA_W-1:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [nvsc_pkg::DATA_W-1:0] rsp_rdata,
  output logic ce_n,
  output logic we_n,
  output logic oe_n,
  output logic nv_sel_n,
  output logic [nvsc_pkg::ADDR_W-1:0] loc_bits,
  output logic [nvsc_pkg::DATA_W-1:0] io_bus_o,
  output logic io_bus_oe_n,
  input wire logic [nvsc_pkg::DATA_W-1:0] io_bus_i
);
  localparam int TW = nvsc_pkg::TMR_W;

  nvsc_pkg::nvsc_state_t state_reg;
  nvsc_pkg::nvsc_state_t state_next;
  logic [nvsc_pkg::OP_W-1:0] op_reg;
  logic [nvsc_pkg::OP_W-1:0] op_next;
  logic ce_n_reg, ce_n_next;
  logic we_n_reg, we_n_next;
  logic oe_n_reg, oe_n_next;
  logic nv_n_reg, nv_n_next;
  logic [nvsc_pkg::ADDR_W-1:0] loc_reg, loc_next;
  logic [nvsc_pkg::DATA_W-1:0] dout_reg, dout_next;
  logic dout_oe_n_reg, dout_oe_n_next;
  logic [nvsc_pkg::DATA_W-1:0] rdata_reg, rdata_next;
  logic ready_reg, ready_next;
  logic rsp_reg, rsp_next;
  logic tmr_load;
  logic [TW-1:0] tmr_val;
  logic tmr_done;

  // One timer serves every phase; only one phase runs at a time
  nvsc_timer #(.W(TW)) u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(tmr_load),
    .load_val(tmr_val),
    .done(tmr_done)
  );

  // Sequencer; every pin moves from its own flop, never a gate
  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    ce_n_next = ce_n_reg;
    we_n_next = we_n_reg;
    oe_n_next = oe_n_reg;
    nv_n_next = nv_n_reg;
    loc_next = loc_reg;
    dout_next = dout_reg;
    dout_oe_n_next = dout_oe_n_reg;
    rdata_next = rdata_reg;
    ready_next = ready_reg;
    rsp_next = 1'b0;
    tmr_load = 1'b0;
    tmr_val = '0;
    case (state_reg)
      nvsc_pkg::ST_PWRUP: begin
        // Chip select and write high: no write state at recall end
        tmr_load = 1'b1;
        tmr_val = TW'(POWERUP_WAIT - 1);
        state_next = nvsc_pkg::ST_BOOT;
      end
      nvsc_pkg::ST_BOOT: begin
        if (tmr_done) begin
          ready_next = 1'b1;
          state_next = nvsc_pkg::ST_IDLE;
        end
      end
      nvsc_pkg::ST_IDLE: begin
        if (cmd_valid && ready_reg) begin
          ready_next = 1'b0;
          op_next = cmd_op;
          // Address set a cycle before read and write strobes fall; store and recall drop all but their last strobe with it
          loc_next = cmd_addr;
          state_next = nvsc_pkg::ST_SETUP;
          case (cmd_op)
            nvsc_pkg::OP_WRITE: begin
              dout_next = cmd_wdata;
              dout_oe_n_next = 1'b0;
            end
            nvsc_pkg::OP_STORE: begin
              // Stage select and chip select; write strobe comes last
              nv_n_next = 1'b0;
              ce_n_next = 1'b0;
            end
            nvsc_pkg::OP_RECALL: begin
              // Stage read state; nonvolatile select falls last
              ce_n_next = 1'b0;
              oe_n_next = 1'b0;
            end
            default: begin
            end
          endcase
        end
      end
      nvsc_pkg::ST_SETUP: begin
        tmr_load = 1'b1;
        tmr_val = TW'(nvsc_pkg::STROBE_CYCLES - 1);
        state_next = nvsc_pkg::ST_ACTIVE;
        case (op_reg)
          nvsc_pkg::OP_READ: begin
            ce_n_next = 1'b0;
            oe_n_next = 1'b0;
            tmr_val = TW'(nvsc_pkg::READ_CYCLES - 1);
          end
          nvsc_pkg::OP_WRITE: begin
            // Output enable stays high to avoid bus contention
            ce_n_next = 1'b0;
            we_n_next = 1'b0;
          end
          nvsc_pkg::OP_STORE: begin
            we_n_next = 1'b0;
          end
          default: begin
            nv_n_next = 1'b0;
          end
        endcase
      end
      nvsc_pkg::ST_ACTIVE: begin
        if (tmr_done) begin
          if (op_reg == nvsc_pkg::OP_READ) begin
            rdata_next = io_bus_i;
          end
          // Write strobe rises while data is still driven
          we_n_next = 1'b1;
          ce_n_next = 1'b1;
          oe_n_next = 1'b1;
          nv_n_next = 1'b1;
          state_next = nvsc_pkg::ST_END;
        end
      end
      nvsc_pkg::ST_END: begin
        dout_oe_n_next = 1'b1;
        if (op_reg == nvsc_pkg::OP_STORE) begin
          tmr_load = 1'b1;
          tmr_val = TW'(STORE_WAIT - 1);
          state_next = nvsc_pkg::ST_WAIT;
        end else if (op_reg == nvsc_pkg::OP_RECALL) begin
          tmr_load = 1'b1;
          tmr_val = TW'(nvsc_pkg::PIN_COPY_CYCLES - 1);
          state_next = nvsc_pkg::ST_WAIT;
        end else begin
          rsp_next = 1'b1;
          ready_next = 1'b1;
          state_next = nvsc_pkg::ST_IDLE;
        end
      end
      nvsc_pkg::ST_WAIT: begin
        // Pins idle while the part copies; it ignores them anyway
        if (tmr_done) begin
          rsp_next = 1'b1;
          ready_next = 1'b1;
          state_next = nvsc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = nvsc_pkg::ST_PWRUP;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= nvsc_pkg::ST_PWRUP;
      op_reg <= nvsc_pkg::OP_READ;
      ce_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      nv_n_reg <= 1'b1;
      loc_reg <= '0;
      dout_reg <= '0;
      dout_oe_n_reg <= 1'b1;
      rdata_reg <= '0;
      ready_reg <= 1'b0;
      rsp_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      ce_n_reg <= ce_n_next;
      we_n_reg <= we_n_next;
      oe_n_reg <= oe_n_next;
      nv_n_reg <= nv_n_next;
      loc_reg <= loc_next;
      dout_reg <= dout_next;
      dout_oe_n_reg <= dout_oe_n_next;
      rdata_reg <= rdata_next;
      ready_reg <= ready_next;
      rsp_reg <= rsp_next;
    end
  end

  assign cmd_ready = ready_reg;
  assign rsp_valid = rsp_reg;
  assign rsp_rdata = rdata_reg;
  assign ce_n = ce_n_reg;
  assign we_n = we_n_reg;
  assign oe_n = oe_n_reg;
  assign nv_sel_n = nv_n_reg;
  assign loc_bits = loc_reg;
  assign io_bus_o = dout_reg;
  assign io_bus_oe_n = dout_oe_n_reg;

  // Cycles since reset, saturating, for the power-up check only
  logic [TW-1:0] since_rst_reg;
  logic [TW-1:0] since_rst_next;
  always_comb begin
    since_rst_next = since_rst_reg;
    if (since_rst_reg != '1) begin
      since_rst_next = since_rst_reg + TW'(1);
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      since_rst_reg <= '0;
    end else begin
      since_rst_reg <= since_rst_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_addr_stable;
    (!ce_n_reg && !we_n_reg) |=> $stable(loc_reg) || we_n_reg;
  endproperty
  a_addr_stable: assert property (p_addr_stable)
    else $error("Address moved during a write");

  // Select level before the edge: a store lifts it in the same cycle
  property p_data_at_end;
    ($rose(we_n_reg) && $past(nv_n_reg)) |->
      !dout_oe_n_reg && $stable(dout_reg);
  endproperty
  a_data_at_end: assert property (p_data_at_end)
    else $error("Write data not driven at end of write");

  property p_oe_high_write;
    (!ce_n_reg && !we_n_reg) |-> oe_n_reg;
  endproperty
  a_oe_high_write: assert property (p_oe_high_write)
    else $error("Output enable low during a write");

  property p_store_last;
    ($fell(we_n_reg) && !nv_n_reg) |->
      !$past(nv_n_reg) && !$past(ce_n_reg) && $past(oe_n_reg);
  endproperty
  a_store_last: assert property (p_store_last)
    else $error("Store not entered last by write strobe");

  property p_boot_wait;
    $fell(ce_n_reg) |-> since_rst_reg >= TW'(POWERUP_WAIT);
  endproperty
  a_boot_wait: assert property (p_boot_wait)
    else $error("Access before power-up recall time");

  property p_boot_no_write;
    (state_reg == nvsc_pkg::ST_BOOT || state_reg == nvsc_pkg::ST_PWRUP)
      |-> ce_n_reg && we_n_reg;
  endproperty
  a_boot_no_write: assert property (p_boot_no_write)
    else $error("Write state during power-up recall");

  property p_store_pulse;
    $fell(we_n_reg) && !nv_n_reg |-> !we_n_reg [*2] ##1 we_n_reg && nv_n_reg;
  endproperty
  a_store_pulse: assert property (p_store_pulse)
    else $error("Store initiation pulse length wrong");

  c_read: cover property (rsp_reg && op_reg == nvsc_pkg::OP_READ);
  c_write: cover property (rsp_reg && op_reg == nvsc_pkg::OP_WRITE);
  c_store: cover property (rsp_reg && op_reg == nvsc_pkg::OP_STORE);
  c_recall: cover property (rsp_reg && op_reg == nvsc_pkg::OP_RECALL);
endmodule
`default_nettype wire

//--- hw/nvsc_pkg.sv
// How it works
// - Host keeps address steady across the whole write.
// - Byte captured at the rising edge ending the write; data valid before.
// - Host keeps output enable high throughout a write.
// - Store starts on select, chip select, write low, output enable high.
// - Host waits the power-up recall time before any SRAM access.
// - Host presents no write state when the power-up recall ends.
package nvsc_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int OP_W = 2;
  localparam int TMR_W = 20;

  // Host command codes
  localparam logic [OP_W-1:0] OP_READ = 2'h0;
  localparam logic [OP_W-1:0] OP_WRITE = 2'h1;
  localparam logic [OP_W-1:0] OP_STORE = 2'h2;
  localparam logic [OP_W-1:0] OP_RECALL = 2'h3;

  // Times in their own units
  localparam int STORE_TIME_MS = 10;
  localparam int PIN_COPY_TIME_US = 20;
  localparam int POWERUP_COPY_TIME_US = 550;
  localparam int STROBE_TIME_NS = 20;
  localparam int READ_ACCESS_NS = 55;

  // Waits the host must honour, rounded up to whole cycles; the read wait gets one cycle more
  localparam int STORE_CYCLES =
    (STORE_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PIN_COPY_CYCLES =
    (PIN_COPY_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POWERUP_COPY_CYCLES =
    (POWERUP_COPY_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYCLES =
    (STROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYCLES =
    (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;

  typedef enum logic [2:0] {
    ST_PWRUP,
    ST_BOOT,
    ST_IDLE,
    ST_SETUP,
    ST_ACTIVE,
    ST_END,
    ST_WAIT
  } nvsc_state_t;
endpackage

//--- hw/nvsc_timer.sv
`timescale 1ns/1ns
`default_nettype none
module nvsc_timer #(
  parameter int W = 20
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic done
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  // Load wins over counting so a new phase always restarts cleanly
  always_comb begin
    cnt_next = cnt_reg;
    if (load) begin
      cnt_next = load_val;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign done = (cnt_reg == '0) && !load;
endmodule
`default_nettype wire

//--- sim/nvsc_device_model.sv
`timescale 1ns/1ns
`default_nettype none
module nvsc_device_model #(
  parameter int STORE_NS = 300,
  parameter int RECALL_NS = 800,
  parameter int BOOT_NS = 200
) (
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic nv_sel_n,
  input wire logic [12:0] loc_bits,
  input wire logic [7:0] io_bus_in,
  output logic [7:0] io_bus_out,
  output logic io_bus_drive_n
);
  logic [7:0] sram [8192];
  logic [7:0] nv [8192];
  logic [7:0] last = 8'h00;
  logic busy = 1'b1;
  int n_store = 0;
  int n_fault = 0;
  // Modes from strobe levels; chip select high deselects all
  wire logic rd = !ce_n && !oe_n && we_n && nv_sel_n;
  wire logic wr = !ce_n && !we_n && nv_sel_n;
  wire logic st = !ce_n && !we_n && oe_n && !nv_sel_n;
  wire logic rc = !ce_n && !oe_n && we_n && !nv_sel_n;
  // Released bus shows the inverse of the last value, not a stale copy
  always @* begin
    io_bus_drive_n = !(rd && !busy);
    io_bus_out = io_bus_drive_n ? ~last : sram[loc_bits];
  end
  always @(io_bus_out) if (!io_bus_drive_n) last = io_bus_out;
  // Byte lands as the write state ends, by either strobe
  always @(negedge wr) if (!busy && nv_sel_n) sram[loc_bits] = io_bus_in;
  // Edge-started, so pins parked in place never retrigger
  always @(posedge st) if (!busy) begin
    busy = 1'b1;
    n_store++;
    for (int i = 0; i < 8192; i++) nv[i] = 8'hFF;
    #(STORE_NS);
    for (int i = 0; i < 8192; i++) nv[i] = sram[i];
    busy = 1'b0;
  end
  task automatic do_recall(input int t);
    busy = 1'b1;
    for (int i = 0; i < 8192; i++) sram[i] = 8'h00;
    #(t);
    for (int i = 0; i < 8192; i++) sram[i] = nv[i];
    busy = 1'b0;
  endtask
  always @(posedge rc) if (!busy) do_recall(RECALL_NS);
  // Known pattern in the array, then the automatic copy at power-up
  initial begin
    for (int i = 0; i < 8192; i++) nv[i] = i[7:0] ^ 8'h5A;
    do_recall(BOOT_NS);
    if (wr) n_fault++;
  end
endmodule
`default_nettype wire

//--- sim/nvsc_host_bench.sv
`timescale 1ns/1ns
`default_nettype none
module nvsc_host_bench;
  localparam int PW = 30;
  localparam int LIMIT = 20000;
  logic clk;
  logic sys_rst;
  logic cmd_valid;
  logic [1:0] cmd_op;
  logic [12:0] cmd_addr;
  logic [7:0] cmd_wdata;
  logic cmd_ready;
  logic rsp_valid;
  logic [7:0] rsp_rdata;
  logic ce_n;
  logic we_n;
  logic oe_n;
  logic nv_sel_n;
  logic [12:0] loc_bits;
  logic [7:0] io_bus_o;
  logic io_bus_oe_n;
  logic [7:0] io_bus_i;
  logic [7:0] dev_out;
  logic dev_drive_n;
  logic [12:0] addr_q;
  logic wr_q = 1'b0;
  logic [7:0] q;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  nvsc_host #(.STORE_WAIT(50), .POWERUP_WAIT(PW)) uut (.clk(clk),
    .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .ce_n(ce_n),
    .we_n(we_n), .oe_n(oe_n), .nv_sel_n(nv_sel_n), .loc_bits(loc_bits),
    .io_bus_o(io_bus_o), .io_bus_oe_n(io_bus_oe_n), .io_bus_i(io_bus_i));
  nvsc_device_model dev (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
    .nv_sel_n(nv_sel_n), .loc_bits(loc_bits), .io_bus_in(io_bus_i),
    .io_bus_out(dev_out), .io_bus_drive_n(dev_drive_n));
  // Two drivers at once resolve to unknown
  assign io_bus_i = !io_bus_oe_n ? (dev_drive_n ? io_bus_o : 8'hXX) : dev_out;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Pin discipline, sampled mid-cycle where strobes are settled
  always @(negedge clk) begin
    if (!sys_rst && !ce_n && !we_n) begin
      check("oe_n in write", 16'(oe_n), 16'h0001);
      if (nv_sel_n) check("data drive", 16'(io_bus_oe_n), 16'h0000);
      if (wr_q) check("write addr", 16'(loc_bits), 16'(addr_q));
    end
    check("contention", 16'(!io_bus_oe_n && !dev_drive_n), 16'h0000);
    wr_q = !ce_n && !we_n;
    addr_q = loc_bits;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic run(input logic [1:0] op, input logic [12:0] a,
                     input logic [7:0] d);
    int k;
    k = 0;
    while (cmd_ready !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    k = 0;
    @(negedge clk);
    while (rsp_valid !== 1'b1 && k < 2100) begin
      @(negedge clk);
      k++;
    end
    check("rsp_valid", 16'(rsp_valid), 16'h0001);
  endtask
  task automatic rd(input logic [12:0] a, output logic [7:0] v);
    run(nvsc_pkg::OP_READ, a, 8'h00);
    v = rsp_rdata;
  endtask
  // Host must sit out the power-up copy with no write state shown
  task automatic t_boot();
    int k;
    k = 0;
    @(negedge clk);
    while (cmd_ready !== 1'b1 && k < 200) begin
      check("idle strobes", 16'({ce_n, we_n}), 16'h0003);
      @(negedge clk);
      k++;
    end
    check("boot wait", 16'(k >= PW), 16'h0001);
    check("boot fault", 16'(dev.n_fault), 16'h0000);
    rd(13'h0123, q);
    check("boot data", 16'(q), 16'h0079);
    $display("test boot done");
  endtask
  // Corner and alternating-bit addresses, written back to back, then read back
  task automatic t_rw();
    logic [12:0] a [3] = '{13'h0000, 13'h1FFF, 13'h0AAA};
    logic [7:0] d [3] = '{8'hA5, 8'h3C, 8'h01};
    for (int i = 0; i < 3; i++) run(nvsc_pkg::OP_WRITE, a[i], d[i]);
    for (int i = 0; i < 3; i++) begin
      rd(a[i], q);
      check("read back", 16'(q), 16'(d[i]));
    end
    $display("test rw done");
  endtask
  // Store, overwrite, then two recalls bring the stored byte back
  task automatic t_nv();
    run(nvsc_pkg::OP_WRITE, 13'h0010, 8'hC3);
    run(nvsc_pkg::OP_STORE, 13'h0000, 8'h00);
    check("store count", 16'(dev.n_store), 16'h0001);
    run(nvsc_pkg::OP_WRITE, 13'h0010, 8'h0F);
    rd(13'h0010, q);
    check("sram after store", 16'(q), 16'h000F);
    for (int i = 0; i < 2; i++) begin
      run(nvsc_pkg::OP_RECALL, 13'h0000, 8'h00);
      rd(13'h0010, q);
      check("recalled", 16'(q), 16'h00C3);
    end
    rd(13'h0011, q);
    check("recalled old", 16'(q), 16'h004B);
    check("store count", 16'(dev.n_store), 16'h0001);
    $display("test nv done");
  endtask
  initial begin
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = 2'h0;
    cmd_addr = 13'h0000;
    cmd_wdata = 8'h00;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_boot();
    t_rw();
    t_nv();
    print_verdict();
  end
endmodule
`default_nettype wire
